// ---- design/rasc_pkg.sv ----
// Constants shared by the relay alarm-status and counter block
package rasc_pkg;
  localparam int        APB_AW        = 12;
  localparam int        APB_DW        = 32;
  // Register byte offsets
  localparam bit [11:0] OFS_CTRL      = 12'h000;
  localparam bit [11:0] OFS_CMD       = 12'h004;
  localparam bit [11:0] OFS_ALARM     = 12'h008;
  localparam bit [11:0] OFS_RATE_WIN  = 12'h00C;
  localparam bit [11:0] OFS_RATE_LIM  = 12'h010;
  localparam bit [11:0] OFS_BRK_SUM   = 12'h014;
  localparam bit [11:0] OFS_CNT_BASE  = 12'h020;
  // Control and command bit positions
  localparam int        CTRL_HOLD     = 0;
  localparam int        CMD_ALM_RST   = 0;
  localparam int        CMD_CTL_RST   = 1;
  localparam int        CMD_FLT_RST   = 2;
  localparam int        CMD_AR_RST    = 3;
  localparam int        CMD_BRK_RST   = 4;
  // Alarm status bit positions
  localparam int        ALM_POS       = 0;
  localparam int        ALM_RATE      = 1;
  localparam int        ALM_HW        = 2;
  localparam int        ALM_BFLT      = 3;
  localparam int        ALM_EXT_LSB   = 4;
  // Counter indices
  localparam int        N_CNT         = 15;
  localparam int        CNT_MAN_TRIP  = 0;
  localparam int        CNT_MAN_CLOSE = 1;
  localparam int        CNT_PROT_TRIP = 2;
  localparam int        CNT_PROT_STRT = 3;
  localparam int        CNT_PROT_ALM  = 4;
  localparam int        CNT_HW_FAULT  = 5;
  localparam int        CNT_AR_START  = 6;
  localparam int        CNT_AR_FINAL  = 7;
  localparam int        CNT_AR_SUCC   = 8;
  localparam int        CNT_SHOT1     = 9;
  localparam int        CNT_CLOSE_TOT = 13;
  localparam int        CNT_OPEN_TOT  = 14;
  // Counter group membership masks
  localparam bit [14:0] GRP_CTL       = 15'h0003;
  localparam bit [14:0] GRP_FLT       = 15'h003C;
  localparam bit [14:0] GRP_AR        = 15'h1FC0;
  localparam bit [14:0] GRP_BRK       = 15'h6000;
  // Event strobe vector positions
  localparam int        N_EV          = 14;
  localparam int        EV_SHOT1      = 9;
  localparam int        EV_FLT_CLR    = 13;
  // Reset values
  localparam bit [31:0] RST_RATE_WIN  = 32'h0000_FFFF;
  localparam bit [31:0] RST_RATE_LIM  = 32'h0000_0004;
endpackage

// ---- design/rasc_top.sv ----
// Relay alarm-status and event-counter block with APB register access
`timescale 1ns/1ps
module rasc_top #(
  parameter int ALM_N_EXT = 22,
  parameter int CNT_W     = 16,
  parameter int CUR_W     = 16
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_b,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [rasc_pkg::APB_AW-1:0]     paddr,
  input  wire logic [rasc_pkg::APB_DW-1:0]     pwdata,
  output logic      [rasc_pkg::APB_DW-1:0]     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [ALM_N_EXT-1:0]            prot_alarm_src,
  input  wire logic [1:0]                      breaker_aux_pos,
  input  wire logic                            hw_warning,
  input  wire logic                            breaker_fault_input,
  input  wire logic                            manual_trip_cmd,
  input  wire logic                            manual_close_cmd,
  input  wire logic                            prot_trip_cmd,
  input  wire logic                            prot_start,
  input  wire logic                            prot_alarm_sig,
  input  wire logic                            ar_seq_start,
  input  wire logic                            ar_final_trip,
  input  wire logic                            ar_reclaim_ok,
  input  wire logic [3:0]                      ar_shot_close,
  input  wire logic                            fault_clear_trip,
  input  wire logic [CUR_W-1:0]                fault_current,
  output logic      [ALM_N_EXT+3:0]            alarm_status,
  output logic                                 alarm_any
);
  import rasc_pkg::*;

  localparam int ALM_W = ALM_N_EXT + 4;

  logic [ALM_N_EXT-1:0] ext_src_q;
  logic [1:0]           aux_pos_q;
  logic                 hw_warn_q;
  logic                 bflt_q;
  logic [N_EV-1:0]      ev_q;
  logic [N_EV-1:0]      ev_prev_q;
  logic [N_EV-1:0]      rise;
  logic [CUR_W-1:0]     cur_q;
  logic [ALM_W-1:0]     alarm_q;
  logic [ALM_W-1:0]     alarm_src;
  logic                 alarm_any_q;
  logic                 hold_q;
  logic [31:0]          rate_win_q;
  logic [31:0]          rate_lim_q;
  logic [31:0]          win_cnt_q;
  logic [31:0]          ar_cyc_q;
  logic [CNT_W-1:0]     cnt_q [N_CNT];
  logic [N_CNT-1:0]     inc;
  logic [N_CNT-1:0]     cnt_clr;
  logic [31:0]          brk_sum_q;
  logic [32:0]          brk_add;
  logic                 pready_q;
  logic                 pslverr_q;
  logic [31:0]          prdata_q;
  logic [31:0]          rd_data;
  logic                 rd_hit;
  logic                 wr_en;
  logic [4:0]           cmd;
  logic [N_EV-1:0]      ev_in;
  logic [ALM_W-1:0]     alarm_d;
  logic [31:0]          brk_sum_d;
  logic                 win_end;
  logic                 apb_setup;

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // Register decode shared by the write, command and read paths
  function automatic logic at_reg(input logic [APB_AW-1:0] a, input logic [11:0] ofs);
    at_reg = (a == ofs);
  endfunction

  // Counters sit in consecutive words from the counter base
  function automatic logic [11:0] cnt_addr(input int idx);
    cnt_addr = OFS_CNT_BASE + 12'(4 * idx);
  endfunction

  // Tallies stick at all-ones rather than wrapping back to zero
  function automatic logic [31:0] sat_inc32(input logic [31:0] v);
    sat_inc32 = (&v) ? v : v + 32'h0000_0001;
  endfunction

  // Alarm sources, one sample per clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_src_q <= '0;
      aux_pos_q <= 2'h1;
      hw_warn_q <= 1'b0;
      bflt_q    <= 1'b0;
    end else begin
      ext_src_q <= prot_alarm_src;
      aux_pos_q <= breaker_aux_pos;
      hw_warn_q <= hw_warning;
      bflt_q    <= breaker_fault_input;
    end
  end

  // Current sample, aligned with the strobe sample so a clearance adds its own value
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_q <= '0;
    end else begin
      cur_q <= fault_current;
    end
  end

  // Strobe vector in counter order; shot and clearance strobes sit on top
  assign ev_in = {fault_clear_trip, ar_shot_close, ar_reclaim_ok, ar_final_trip,
                  ar_seq_start, hw_warning, prot_alarm_sig, prot_start,
                  prot_trip_cmd, manual_close_cmd, manual_trip_cmd};

  // Strobe sample
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_q <= '0;
    end else begin
      ev_q <= ev_in;
    end
  end

  // Previous sample; resets to the idle level so reset makes no false edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_prev_q <= '0;
    end else begin
      ev_prev_q <= ev_q;
    end
  end

  // One count per strobe, however long it is held
  assign rise = ev_q & ~ev_prev_q;

  // APB decode
  assign apb_setup = psel & ~penable;
  assign wr_en     = psel & penable & pready_q & pwrite;
  assign cmd       = (wr_en && at_reg(paddr, OFS_CMD)) ? pwdata[4:0] : 5'h00;

  // Alarm hold mode: 0 self-reset, 1 latching
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 1'b0;
    end else if (wr_en && at_reg(paddr, OFS_CTRL)) begin
      hold_q <= pwdata[CTRL_HOLD];
    end
  end

  // Reclose-rate window length in clocks, less one
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_win_q <= RST_RATE_WIN;
    end else if (wr_en && at_reg(paddr, OFS_RATE_WIN)) begin
      rate_win_q <= pwdata;
    end
  end

  // Reclose-rate limit
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rate_lim_q <= RST_RATE_LIM;
    end else if (wr_en && at_reg(paddr, OFS_RATE_LIM)) begin
      rate_lim_q <= pwdata;
    end
  end

  // Reclose-rate window; fixed windows, not sliding, to keep it cheap
  assign win_end = (win_cnt_q >= rate_win_q);

  // Window position in clocks
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_cnt_q <= '0;
    end else if (win_end) begin
      win_cnt_q <= '0;
    end else begin
      win_cnt_q <= win_cnt_q + 32'h0000_0001;
    end
  end

  // Starts in the current window; a start on the boundary opens the next tally
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ar_cyc_q <= '0;
    end else if (win_end) begin
      ar_cyc_q <= {31'h0000_0000, rise[CNT_AR_START]};
    end else if (rise[CNT_AR_START]) begin
      ar_cyc_q <= sat_inc32(ar_cyc_q);
    end
  end

  // Alarm source vector
  always_comb begin
    alarm_src                = '0;
    alarm_src[ALM_POS]       = ~(aux_pos_q[0] ^ aux_pos_q[1]);
    alarm_src[ALM_RATE]      = ar_cyc_q > rate_lim_q;
    alarm_src[ALM_HW]        = hw_warn_q;
    alarm_src[ALM_BFLT]      = bflt_q;
    alarm_src[ALM_W-1:ALM_EXT_LSB] = ext_src_q;
  end

  // Next alarm vector; a present condition wins over the reset command
  always_comb begin
    alarm_d = alarm_src;
    if (hold_q) begin
      alarm_d = (alarm_q & {ALM_W{~cmd[CMD_ALM_RST]}}) | alarm_src;
    end
  end

  // Alarm status register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  // Summary built from the same next value, so both change on one edge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alarm_any_q <= 1'b0;
    end else begin
      alarm_any_q <= |alarm_d;
    end
  end

  // Increment sources per counter
  always_comb begin
    inc                = '0;
    inc[CNT_MAN_TRIP]  = rise[CNT_MAN_TRIP];
    inc[CNT_MAN_CLOSE] = rise[CNT_MAN_CLOSE];
    inc[CNT_PROT_TRIP] = rise[CNT_PROT_TRIP];
    inc[CNT_PROT_STRT] = rise[CNT_PROT_STRT];
    inc[CNT_PROT_ALM]  = rise[CNT_PROT_ALM];
    inc[CNT_HW_FAULT]  = rise[CNT_HW_FAULT];
    inc[CNT_AR_START]  = rise[CNT_AR_START];
    inc[CNT_AR_FINAL]  = rise[CNT_AR_FINAL];
    inc[CNT_AR_SUCC]   = rise[CNT_AR_SUCC];
    inc[CNT_SHOT1+3:CNT_SHOT1] = rise[EV_SHOT1+3:EV_SHOT1];
    inc[CNT_CLOSE_TOT] = rise[CNT_MAN_CLOSE] | (|rise[EV_SHOT1+3:EV_SHOT1]);
    inc[CNT_OPEN_TOT]  = rise[CNT_MAN_TRIP] | rise[CNT_PROT_TRIP];
  end

  // Group clears
  assign cnt_clr = (GRP_CTL & {N_CNT{cmd[CMD_CTL_RST]}})
                 | (GRP_FLT & {N_CNT{cmd[CMD_FLT_RST]}})
                 | (GRP_AR  & {N_CNT{cmd[CMD_AR_RST]}})
                 | (GRP_BRK & {N_CNT{cmd[CMD_BRK_RST]}});

  // Event counters
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N_CNT; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < N_CNT; i++) begin
        if (cnt_clr[i]) begin
          cnt_q[i] <= '0;
        end else if (inc[i]) begin
          cnt_q[i] <= sat_inc(cnt_q[i]);
        end
      end
    end
  end

  // Broken current accumulator; sticks at all-ones on overflow
  assign brk_add = {1'b0, brk_sum_q} + {{(33-CUR_W){1'b0}}, cur_q};

  always_comb begin
    brk_sum_d = brk_sum_q;
    if (cmd[CMD_BRK_RST]) begin
      brk_sum_d = '0;
    end else if (rise[EV_FLT_CLR]) begin
      brk_sum_d = brk_add[32] ? 32'hFFFF_FFFF : brk_add[31:0];
    end
  end

  // Sum register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      brk_sum_q <= '0;
    end else begin
      brk_sum_q <= brk_sum_d;
    end
  end

  // Read mux
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr)
      OFS_CTRL:     rd_data = {31'h0000_0000, hold_q};
      OFS_CMD:      rd_data = 32'h0000_0000;
      OFS_ALARM:    rd_data = 32'(alarm_q);
      OFS_RATE_WIN: rd_data = rate_win_q;
      OFS_RATE_LIM: rd_data = rate_lim_q;
      OFS_BRK_SUM:  rd_data = brk_sum_q;
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < N_CNT; i++) begin
          if (at_reg(paddr, cnt_addr(i))) begin
            rd_data = 32'(cnt_q[i]);
            rd_hit  = 1'b1;
          end
        end
      end
    endcase
  end

  // APB slave: ready in the cycle after setup, so no access waits
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= apb_setup;
    end
  end

  // Error on unmapped address; such a write decodes to nothing
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= apb_setup & ~rd_hit;
    end
  end

  // Read data taken at setup, zero for writes; held until the next setup
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= '0;
    end else if (apb_setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
    end
  end

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign alarm_status = alarm_q;
  assign alarm_any    = alarm_any_q;
endmodule

// ---- dv/rasc_top_assertions.sv ----
// Port-level checks for the alarm status block
`timescale 1ns/1ps
module rasc_top_assertions #(
  parameter int ALM_N_EXT = 22
) (
  input wire logic                        ref_clk,
  input wire logic                        rst_b,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [rasc_pkg::APB_AW-1:0] paddr,
  input wire logic [rasc_pkg::APB_DW-1:0] pwdata,
  input wire logic [rasc_pkg::APB_DW-1:0] prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire logic [ALM_N_EXT-1:0]        prot_alarm_src,
  input wire logic [1:0]                  breaker_aux_pos,
  input wire logic                        hw_warning,
  input wire logic                        breaker_fault_input,
  input wire logic [ALM_N_EXT+3:0]        alarm_status,
  input wire logic                        alarm_any
);
  import rasc_pkg::*;
  logic [1:0] warm_q;
  logic       hold_q;
  logic       wr_acc;
  logic       alm_clr;
  assign wr_acc = psel && penable && pready && pwrite;
  assign alm_clr = wr_acc && paddr == OFS_CMD && pwdata[CMD_ALM_RST];
  // Two-stage sampling: skip checks until samples taken after reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) warm_q <= 2'h0;
    else if (warm_q != 2'h3) warm_q <= warm_q + 2'h1;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) hold_q <= 1'b0;
    else if (wr_acc && paddr == OFS_CTRL) hold_q <= pwdata[CTRL_HOLD];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable && pready; endsequence
  apb_answer_a: assert property (setup_s |=> access_s) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held high");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  unmapped_err_a: assert property (psel && penable && pready && paddr == 12'hFFC |-> pslverr)
    else $error("unmapped address not refused");
  write_rdata_a: assert property (psel && penable && pready && pwrite |-> prdata == 32'h0)
    else $error("read data on a write");
  pos_alarm_a: assert property (warm_q == 2'h3 && ^$past(breaker_aux_pos, 2) == 1'b0 |->
    alarm_status[ALM_POS]) else $error("position alarm missing");
  hw_alarm_a: assert property (warm_q == 2'h3 && $past(hw_warning, 2) |->
    alarm_status[ALM_HW]) else $error("hardware alarm missing");
  ext_alarm_a: assert property (warm_q == 2'h3 |-> (alarm_status[ALM_N_EXT+3:ALM_EXT_LSB]
    & $past(prot_alarm_src, 2)) == $past(prot_alarm_src, 2)) else $error("source alarm lost");
  self_reset_a: assert property (warm_q == 2'h3 && !hold_q && !$past(hold_q)
    && !$past(hold_q, 2) && !$past(breaker_fault_input, 2) |-> !alarm_status[ALM_BFLT])
    else $error("alarm stuck in self-reset mode");
  latch_hold_a: assert property (hold_q && $past(hold_q) && $past(hold_q, 2)
    && $past(alarm_status[ALM_BFLT]) && !$past(alm_clr) && !$past(alm_clr, 2)
    && !$past(alm_clr, 3) |-> alarm_status[ALM_BFLT]) else $error("latched alarm dropped");
  any_alarm_a: assert property (alarm_any == (|alarm_status)) else $error("summary mismatch");
endmodule
bind rasc_top rasc_top_assertions #(.ALM_N_EXT(ALM_N_EXT)) rasc_top_assertions_i (.ref_clk,
  .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .prot_alarm_src, .breaker_aux_pos, .hw_warning, .breaker_fault_input, .alarm_status,
  .alarm_any);

// ---- dv/testbench.sv ----
// Self-checking bench for the alarm status and counter block
`timescale 1ns/1ps
module testbench;
  import rasc_pkg::*;
  localparam int CW = 4;
  logic                 ref_clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [APB_AW-1:0]    paddr = '0;
  logic [APB_DW-1:0]    pwdata = '0;
  logic [APB_DW-1:0]    prdata;
  logic                 pready;
  logic                 pslverr;
  logic [21:0]          alm_src = '0;
  logic [21:0]          src;
  logic [1:0]           aux = 2'h1;
  logic                 bfi = 1'b0;
  logic [N_EV-1:0]      ev = '0;
  logic [15:0]          cur = '0;
  logic [25:0]          alarm_status;
  logic                 alarm_any;
  logic [31:0]          exp_q [N_CNT];
  logic [31:0]          sum_exp = '0;
  logic [31:0]          rd;
  logic [14:0]          m;
  logic                 er;
  int                   err_total = 0;
  int                   cmp_count = 0;
  int                   seed = 61;
  always #4 ref_clk = ~ref_clk;
  // Small counter width so saturation is reached in a short run
  rasc_top #(.CNT_W(CW)) rasc_top_i (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .prot_alarm_src(alm_src), .breaker_aux_pos(aux),
    .hw_warning(ev[5]), .breaker_fault_input(bfi), .manual_trip_cmd(ev[0]),
    .manual_close_cmd(ev[1]), .prot_trip_cmd(ev[2]), .prot_start(ev[3]),
    .prot_alarm_sig(ev[4]), .ar_seq_start(ev[6]), .ar_final_trip(ev[7]),
    .ar_reclaim_ok(ev[8]), .ar_shot_close(ev[12:9]), .fault_clear_trip(ev[13]),
    .fault_current(cur), .alarm_status, .alarm_any);
  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask
  function automatic void bump(int c);
    if (exp_q[c] < 2 ** CW - 1) exp_q[c] = exp_q[c] + 1;
  endfunction
  function automatic void model(int i);
    if (i == EV_FLT_CLR) sum_exp = sum_exp + {16'h0, cur};
    else bump(i);
    if (i == 0 || i == 2) bump(CNT_OPEN_TOT);
    if (i == 1 || (i >= EV_SHOT1 && i < EV_FLT_CLR)) bump(CNT_CLOSE_TOT);
  endfunction
  // A held strobe must count once; low for two cycles before the next
  task automatic fire(input int i, input int len);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    cur <= 16'($random(seed));
    repeat (len) @(posedge ref_clk);
    ev[i] <= 1'b0;
    @(posedge ref_clk);
    model(i);
  endtask
  task automatic check_all();
    for (int c = 0; c < N_CNT; c++) begin
      apb(1'b0, OFS_CNT_BASE + 12'(4 * c), 32'h0);
      chk(rd, exp_q[c]);
    end
    apb(1'b0, OFS_BRK_SUM, 32'h0);
    chk(rd, sum_exp);
  endtask
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  initial begin
    for (int c = 0; c < N_CNT; c++) exp_q[c] = '0;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_RATE_WIN, 32'h0);
    chk(rd, RST_RATE_WIN);
    apb(1'b0, OFS_RATE_LIM, 32'h0);
    chk(rd, RST_RATE_LIM);
    apb(1'b0, 12'hFFC, 32'h0);
    chk({31'h0, er}, 32'h1);
    check_all();
    apb(1'b1, OFS_RATE_WIN, 32'h14);
    apb(1'b1, OFS_RATE_LIM, 32'h1);
    apb(1'b0, OFS_RATE_WIN, 32'h0);
    chk(rd, 32'h14);
    for (int h = 0; h < 2; h++) begin
      apb(1'b1, OFS_CTRL, 32'(h));
      src = 22'($random(seed));
      alm_src <= src;
      bfi <= 1'b1;
      aux <= h ? 2'h0 : 2'h3;
      repeat (4) @(posedge ref_clk);
      apb(1'b0, OFS_ALARM, 32'h0);
      chk(rd, {6'h0, src, 4'h9});
      alm_src <= '0;
      bfi <= 1'b0;
      aux <= 2'h1;
      repeat (4) @(posedge ref_clk);
      apb(1'b0, OFS_ALARM, 32'h0);
      chk(rd, h ? {6'h0, src, 4'h9} : 32'h0);
    end
    apb(1'b1, OFS_CMD, 32'h1);
    apb(1'b0, OFS_ALARM, 32'h0);
    chk(rd, 32'h0);
    repeat (3) fire(6, 1);
    apb(1'b0, OFS_ALARM, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h0);
    for (int k = 0; k < 90; k++) fire($unsigned($random(seed)) % N_EV, 1 + ($random(seed) & 3));
    check_all();
    for (int g = 1; g < 5; g++) begin
      apb(1'b1, OFS_CMD, 32'h1 << g);
      m = g == 1 ? GRP_CTL : g == 2 ? GRP_FLT : g == 3 ? GRP_AR : GRP_BRK;
      for (int c = 0; c < N_CNT; c++) if (m[c]) exp_q[c] = '0;
      if (g == 4) sum_exp = '0;
      check_all();
    end
    wrap_up();
  end
endmodule
